// ==== hw/power_mode_pkg.sv ====
// Purpose: Shared constants and types of the power mode controller
// Assumes: 10 MHz system clock, word-aligned Wishbone register map
// Notes:   Times are in ns; cycle counts derive from the clock period
package power_mode_pkg;

	typedef enum logic [2:0] {
		MODE_ACTIVE,
		MODE_SLEEP,
		MODE_LOW_POWER,
		MODE_MICRO_POWER,
		MODE_STANDBY,
		MODE_BACKUP,
		MODE_POWER_DOWN
	} mode_t;

	typedef enum logic [1:0] {
		SEQ_INIT,
		SEQ_OSC,
		SEQ_RUN
	} seq_t;

	localparam logic [2:0]  MODE_CODE_MAX   = 3'h6;

	// Register byte offsets
	localparam logic [7:0]  ADDR_CTRL       = 8'h00;
	localparam logic [7:0]  ADDR_CFG        = 8'h04;
	localparam logic [7:0]  ADDR_IRQ_EN     = 8'h08;
	localparam logic [7:0]  ADDR_STATUS     = 8'h0C;
	localparam logic [7:0]  ADDR_WAKE_CAUSE = 8'h10;

	// Configuration field positions
	localparam int          CFG_ICACHE      = 0;
	localparam int          CFG_PRIMARY_OFF = 1;
	localparam int          CFG_ACCEL_SLEEP = 2;
	localparam int          CFG_ACCEL_RET   = 3;
	localparam int          CFG_BANK_RET_LO = 4;
	localparam logic [7:0]  CFG_RESET       = 8'hF0;
	localparam logic [15:0] IRQ_EN_RESET    = 16'h0000;

	// Wake source bit positions
	localparam int          WAKE_W          = 18;
	localparam int          W_SPI           = 0;
	localparam int          W_AUDIO         = 1;
	localparam int          W_I2C           = 2;
	localparam int          W_UART          = 3;
	localparam int          W_TIMER         = 4;
	localparam int          W_WDT           = 5;
	localparam int          W_WAKE_TIMER    = 6;
	localparam int          W_CMP_ANY       = 7;
	localparam int          W_RTC           = 8;
	localparam int          W_GPIO          = 9;
	localparam int          W_COPROC        = 10;
	localparam int          W_LP_UART       = 11;
	localparam int          W_LP_TMR_A      = 12;
	localparam int          W_LP_TMR_B      = 13;
	localparam int          W_LP_WDT        = 14;
	localparam int          W_CMP_ZERO      = 15;
	localparam int          W_P3_ZERO       = 16;
	localparam int          W_P3_ONE        = 17;
	localparam int          CAUSE_PIN       = 18;
	localparam int          CAUSE_IRQ       = 19;

	localparam logic [WAKE_W-1:0] WAKE_LPM_MASK = 18'h007FF;
	localparam logic [WAKE_W-1:0] WAKE_MPM_MASK = 18'h07BC0;
	localparam logic [WAKE_W-1:0] WAKE_STB_MASK = 18'h08340;
	localparam logic [WAKE_W-1:0] WAKE_PDM_MASK = 18'h30000;

	// Restart timing
	localparam int unsigned CLK_PERIOD_NS   = 100;
	localparam int unsigned OSC_START_NS    = 1000;
	localparam int unsigned SYS_INIT_NS     = 5000;
	localparam int unsigned OSC_START_CYC   =
		(OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SYS_INIT_CYC    =
		(SYS_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ==== hw/power_mode_controller.sv ====
// Purpose: Chip power mode sequencer with Wishbone register access
// Assumes: Inputs synchronous to sys_clk_i, reset pin low is asserted
// Notes:   Overview of operation below; all outputs are registered
//
// Overview of operation
// - Active: both cores run; coprocessor reaches only banks two and three
// - Bank three usable as coprocessor cache in active and low power
// - Active mode clocks only peripherals currently requesting a clock
// - Sleep halts cores, peripherals and DMA stay, accelerator per setting
// - Sleep exits on any enabled peripheral interrupt or reset pin
// - Low power: main core, banks zero/one retained; coprocessor keeps running
// - Low power: DMA reads flash, primary optional, other oscillators on
// - Low power return skips system initialization, faster than backup
// - Low power exits on listed peripherals, reset pin or coprocessor
// - Micro power retains cores, banks, holds GPIO, accelerator off
// - Micro power retains peripherals; primary, secondary off; rest on
// - Micro power exits on listed low-power sources or reset pin
// - Standby retains all, stops primary, secondary and baud oscillators
// - Standby and backup exit only on RTC, timer, GPIO, comparator, pin
// - Backup: cores, peripherals off, per-bank retention, two oscillators
// - Power down: all off, monitors on, wake on port three pins, pin
// - Oscillators follow mode entry and exit with no software action
//
// Decided for this implementation: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
module power_mode_controller #(
	parameter int N_PERIPH = 16
) (
	input  wire logic                               sys_clk_i,
	input  wire logic                               reset_i,
	input  wire logic                               wb_cyc_i,
	input  wire logic                               wb_stb_i,
	input  wire logic                               wb_we_i,
	input  wire logic [7:0]                         wb_adr_i,
	input  wire logic [3:0]                         wb_sel_i,
	input  wire logic [31:0]                        wb_dat_i,
	output logic      [31:0]                        wb_dat_o,
	output logic                                    wb_ack_o,
	input  wire logic                               external_reset_pin_n_i,
	input  wire logic [power_mode_pkg::WAKE_W-1:0]  wake_i,
	input  wire logic [N_PERIPH-1:0]                periph_irq_i,
	input  wire logic [N_PERIPH-1:0]                periph_req_i,
	output power_mode_pkg::mode_t                   mode_o,
	output logic                                    main_core_pwr_o,
	output logic                                    main_core_run_o,
	output logic                                    cop_core_pwr_o,
	output logic                                    cop_core_run_o,
	output logic      [3:0]                         bank_pwr_o,
	output logic      [3:0]                         bank_retain_o,
	output logic      [3:0]                         cop_bank_access_o,
	output logic                                    bank3_icache_o,
	output logic                                    accel_quad_pwr_o,
	output logic                                    accel_mem_retain_o,
	output logic                                    periph_pwr_o,
	output logic                                    periph_run_o,
	output logic      [N_PERIPH-1:0]                periph_clk_en_o,
	output logic                                    dma_en_o,
	output logic                                    dma_flash_en_o,
	output logic                                    gpio_hold_o,
	output logic                                    primary_osc_en_o,
	output logic                                    secondary_osc_en_o,
	output logic                                    baud_osc_en_o,
	output logic                                    rtc_crystal_osc_en_o,
	output logic                                    nano_ring_osc_en_o,
	output logic                                    volt_mon_en_o
);
	import power_mode_pkg::*;

	generate
		if (N_PERIPH < 1 || N_PERIPH > 16) begin : g_bad_width
			$error("N_PERIPH must lie between 1 and 16");
		end
	endgenerate

	typedef struct packed {
		logic                  ack;
		logic [31:0]           dat;
		mode_t                 mode;
		seq_t                  seq;
		logic [7:0]            cnt;
		logic                  cold;
		logic [7:0]            cfg;
		logic [15:0]           irq_en;
		logic [19:0]           cause;
		logic                  mc_pwr;
		logic                  mc_run;
		logic                  cp_pwr;
		logic                  cp_run;
		logic [3:0]            bank_pwr;
		logic [3:0]            bank_ret;
		logic [3:0]            cop_acc;
		logic                  icache;
		logic                  accel_q;
		logic                  accel_ret;
		logic                  per_pwr;
		logic                  per_run;
		logic [N_PERIPH-1:0]   clk_en;
		logic                  dma;
		logic                  dma_flash;
		logic                  gpio_hold;
		logic                  osc_pri;
		logic                  osc_sec;
		logic                  osc_baud;
		logic                  osc_xtal;
		logic                  osc_nano;
		logic                  vmon;
	} state_t;

	state_t s;
	state_t next_s;

	logic                  req;
	logic                  wr;
	logic                  pin_wake;
	logic                  irq_wake;
	logic [WAKE_W-1:0]     allowed;
	logic                  wake;
	logic [15:0]           irq_vec;

	always_comb begin
		next_s = s;
		req = wb_cyc_i & wb_stb_i & ~s.ack;
		wr = req & wb_we_i;
		next_s.ack = req;
		irq_vec = 16'h0000;
		irq_vec[N_PERIPH-1:0] = periph_irq_i;
		pin_wake = ~external_reset_pin_n_i;
		irq_wake = 1'b0;
		// Each mode only listens to its own wake set
		case (s.mode)
			MODE_SLEEP: begin
				allowed = '0;
				irq_wake = |(irq_vec & s.irq_en);
			end
			MODE_LOW_POWER:   allowed = WAKE_LPM_MASK;
			MODE_MICRO_POWER: allowed = WAKE_MPM_MASK;
			MODE_STANDBY:     allowed = WAKE_STB_MASK;
			MODE_BACKUP:      allowed = WAKE_STB_MASK;
			MODE_POWER_DOWN:  allowed = WAKE_PDM_MASK;
			default:          allowed = '0;
		endcase
		wake = pin_wake | irq_wake | |(wake_i & allowed);

		// Register reads answer from current state
		if (req && !wb_we_i) begin
			case (wb_adr_i)
				ADDR_CTRL:       next_s.dat = {29'h0, s.mode};
				ADDR_CFG:        next_s.dat = {24'h0, s.cfg};
				ADDR_IRQ_EN:     next_s.dat = {16'h0, s.irq_en};
				ADDR_STATUS:     next_s.dat = {27'h0, s.seq, s.mode};
				ADDR_WAKE_CAUSE: next_s.dat = {12'h0, s.cause};
				default:         next_s.dat = 32'h0000_0000;
			endcase
		end else begin
			next_s.dat = 32'h0000_0000;
		end
		if (wr && wb_adr_i == ADDR_CFG && wb_sel_i[0]) begin
			next_s.cfg = wb_dat_i[7:0];
		end
		if (wr && wb_adr_i == ADDR_IRQ_EN) begin
			if (wb_sel_i[0]) begin
				next_s.irq_en[7:0] = wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				next_s.irq_en[15:8] = wb_dat_i[15:8];
			end
		end

		// Mode sequencer
		case (s.seq)
			SEQ_RUN: begin
				if (s.mode != MODE_ACTIVE && wake) begin
					next_s.cause = {irq_wake, pin_wake,
						wake_i & allowed};
					next_s.seq = SEQ_OSC;
					next_s.cnt = 8'(OSC_START_CYC - 1);
					next_s.cold = (s.mode == MODE_BACKUP) ||
						(s.mode == MODE_POWER_DOWN);
				end else if (wr && wb_adr_i == ADDR_CTRL && wb_sel_i[0] &&
						s.mode == MODE_ACTIVE &&
						wb_dat_i[2:0] <= MODE_CODE_MAX) begin
					next_s.mode = mode_t'(wb_dat_i[2:0]);
					next_s.cause = 20'h00000;
				end
			end
			SEQ_OSC: begin
				if (s.cnt == 8'h00) begin
					// Warm return skips the init wait
					if (s.cold) begin
						next_s.seq = SEQ_INIT;
						next_s.cnt = 8'(SYS_INIT_CYC - 1);
					end else begin
						next_s.seq = SEQ_RUN;
						next_s.mode = MODE_ACTIVE;
					end
				end else begin
					next_s.cnt = s.cnt - 8'h01;
				end
			end
			SEQ_INIT: begin
				if (s.cnt == 8'h00) begin
					next_s.seq = SEQ_RUN;
					next_s.mode = MODE_ACTIVE;
					next_s.cold = 1'b0;
				end else begin
					next_s.cnt = s.cnt - 8'h01;
				end
			end
			default: next_s.seq = SEQ_INIT;
		endcase

		// Domain controls follow the next mode
		next_s.mc_pwr = 1'b0;
		next_s.mc_run = 1'b0;
		next_s.cp_pwr = 1'b0;
		next_s.cp_run = 1'b0;
		next_s.bank_pwr = 4'h0;
		next_s.bank_ret = 4'h0;
		next_s.cop_acc = 4'h0;
		next_s.icache = 1'b0;
		next_s.accel_q = 1'b0;
		next_s.accel_ret = 1'b0;
		next_s.per_pwr = 1'b0;
		next_s.per_run = 1'b0;
		next_s.clk_en = '0;
		next_s.dma = 1'b0;
		next_s.dma_flash = 1'b0;
		next_s.gpio_hold = 1'b0;
		next_s.osc_pri = 1'b0;
		next_s.osc_sec = 1'b0;
		next_s.osc_baud = 1'b0;
		next_s.osc_xtal = 1'b1;
		next_s.osc_nano = 1'b1;
		next_s.vmon = 1'b1;
		if (next_s.seq != SEQ_RUN) begin
			// Clocks come back before any core is released
			next_s.osc_pri = 1'b1;
			next_s.osc_sec = 1'b1;
			next_s.osc_baud = 1'b1;
			next_s.mc_pwr = 1'b1;
			next_s.cp_pwr = 1'b1;
			next_s.bank_pwr = 4'hF;
			next_s.per_pwr = 1'b1;
			next_s.gpio_hold = 1'b1;
		end else begin
			case (next_s.mode)
				MODE_ACTIVE: begin
					next_s.mc_pwr = 1'b1;
					next_s.mc_run = 1'b1;
					next_s.cp_pwr = 1'b1;
					next_s.cp_run = 1'b1;
					next_s.bank_pwr = 4'hF;
					next_s.cop_acc = 4'hC;
					next_s.icache = next_s.cfg[CFG_ICACHE];
					next_s.accel_q = 1'b1;
					next_s.per_pwr = 1'b1;
					next_s.per_run = 1'b1;
					next_s.clk_en = periph_req_i;
					next_s.dma = 1'b1;
					next_s.dma_flash = 1'b1;
					next_s.osc_pri = 1'b1;
					next_s.osc_sec = 1'b1;
					next_s.osc_baud = 1'b1;
				end
				MODE_SLEEP: begin
					next_s.mc_pwr = 1'b1;
					next_s.cp_pwr = 1'b1;
					next_s.bank_pwr = 4'hF;
					next_s.accel_q = next_s.cfg[CFG_ACCEL_SLEEP];
					next_s.per_pwr = 1'b1;
					next_s.per_run = 1'b1;
					next_s.clk_en = periph_req_i;
					next_s.dma = 1'b1;
					next_s.osc_pri = 1'b1;
					next_s.osc_sec = 1'b1;
					next_s.osc_baud = 1'b1;
				end
				MODE_LOW_POWER: begin
					next_s.mc_pwr = 1'b1;
					next_s.cp_pwr = 1'b1;
					next_s.cp_run = 1'b1;
					next_s.bank_pwr = 4'hC;
					next_s.bank_ret = 4'h3;
					next_s.cop_acc = 4'hC;
					next_s.icache = next_s.cfg[CFG_ICACHE];
					next_s.accel_q = 1'b1;
					next_s.per_pwr = 1'b1;
					next_s.per_run = 1'b1;
					next_s.clk_en = periph_req_i;
					next_s.dma = 1'b1;
					next_s.dma_flash = 1'b1;
					next_s.osc_pri = ~next_s.cfg[CFG_PRIMARY_OFF];
					next_s.osc_sec = 1'b1;
					next_s.osc_baud = 1'b1;
				end
				MODE_MICRO_POWER, MODE_STANDBY: begin
					next_s.mc_pwr = 1'b1;
					next_s.cp_pwr = 1'b1;
					next_s.bank_ret = 4'hF;
					next_s.accel_ret = next_s.cfg[CFG_ACCEL_RET];
					next_s.per_pwr = 1'b1;
					next_s.gpio_hold = 1'b1;
					// Standby drops the baud source as well
					next_s.osc_baud = (next_s.mode == MODE_MICRO_POWER);
				end
				MODE_BACKUP: begin
					next_s.bank_ret = next_s.cfg[CFG_BANK_RET_LO +: 4];
					next_s.accel_ret = next_s.cfg[CFG_ACCEL_RET];
				end
				MODE_POWER_DOWN: begin
					next_s.osc_xtal = 1'b0;
					next_s.osc_nano = 1'b0;
				end
				default: next_s.mode = MODE_ACTIVE;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			s <= '0;
			s.cfg <= CFG_RESET;
			s.irq_en <= IRQ_EN_RESET;
			// Clocks run through reset so the first core release follows them
			s.osc_pri <= 1'b1;
			s.osc_sec <= 1'b1;
			s.osc_baud <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign wb_dat_o = s.dat;
	assign wb_ack_o = s.ack;
	assign mode_o = s.mode;
	assign main_core_pwr_o = s.mc_pwr;
	assign main_core_run_o = s.mc_run;
	assign cop_core_pwr_o = s.cp_pwr;
	assign cop_core_run_o = s.cp_run;
	assign bank_pwr_o = s.bank_pwr;
	assign bank_retain_o = s.bank_ret;
	assign cop_bank_access_o = s.cop_acc;
	assign bank3_icache_o = s.icache;
	assign accel_quad_pwr_o = s.accel_q;
	assign accel_mem_retain_o = s.accel_ret;
	assign periph_pwr_o = s.per_pwr;
	assign periph_run_o = s.per_run;
	assign periph_clk_en_o = s.clk_en;
	assign dma_en_o = s.dma;
	assign dma_flash_en_o = s.dma_flash;
	assign gpio_hold_o = s.gpio_hold;
	assign primary_osc_en_o = s.osc_pri;
	assign secondary_osc_en_o = s.osc_sec;
	assign baud_osc_en_o = s.osc_baud;
	assign rtc_crystal_osc_en_o = s.osc_xtal;
	assign nano_ring_osc_en_o = s.osc_nano;
	assign volt_mon_en_o = s.vmon;

	localparam int OSC_WAIT_MAX = int'(OSC_START_CYC) + 1;

	AST_ACTIVE_BANKS: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(s.seq == SEQ_RUN && s.mode == MODE_ACTIVE) |->
		(main_core_run_o && cop_core_run_o && bank_pwr_o == 4'hF &&
		cop_bank_access_o == 4'hC))
		else $error("active mode bank access wrong");
	AST_ICACHE_MODES: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		bank3_icache_o |->
		(mode_o == MODE_ACTIVE || mode_o == MODE_LOW_POWER))
		else $error("cache option outside active or low power");
	AST_DYN_CLOCK: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(s.seq == SEQ_RUN && s.mode == MODE_ACTIVE) |->
		periph_clk_en_o == $past(periph_req_i))
		else $error("peripheral clock does not follow request");
	AST_SLEEP_STATE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(s.seq == SEQ_RUN && s.mode == MODE_SLEEP) |->
		(!main_core_run_o && !cop_core_run_o && periph_pwr_o && dma_en_o))
		else $error("sleep domain state wrong");
	AST_SLEEP_WAKE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(s.seq == SEQ_RUN && s.mode == MODE_SLEEP &&
		(|(irq_vec & s.irq_en) || !external_reset_pin_n_i)) |=>
		s.seq == SEQ_OSC)
		else $error("sleep did not start wake");
	AST_LPM_STATE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(s.seq == SEQ_RUN && s.mode == MODE_LOW_POWER) |->
		(!main_core_run_o && cop_core_run_o && bank_retain_o == 4'h3 &&
		dma_flash_en_o && baud_osc_en_o && secondary_osc_en_o))
		else $error("low power domain state wrong");
	AST_LPM_FAST: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(s.seq == SEQ_RUN && s.mode == MODE_LOW_POWER && wake) |->
		##[1:OSC_WAIT_MAX] (main_core_run_o && mode_o == MODE_ACTIVE))
		else $error("low power return too slow");
	AST_MPM_STATE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(s.seq == SEQ_RUN && s.mode == MODE_MICRO_POWER) |->
		(!accel_quad_pwr_o && gpio_hold_o && !primary_osc_en_o &&
		!secondary_osc_en_o && baud_osc_en_o && !periph_run_o))
		else $error("micro power domain state wrong");
	AST_STANDBY_HOLD: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(s.seq == SEQ_RUN && s.mode == MODE_STANDBY &&
		external_reset_pin_n_i && !(|(wake_i & WAKE_STB_MASK))) |=>
		(s.seq == SEQ_RUN && mode_o == MODE_STANDBY))
		else $error("standby left without allowed source");
	AST_BACKUP_RET: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(s.seq == SEQ_RUN && s.mode == MODE_BACKUP) |->
		(bank_retain_o == s.cfg[7:4] && !baud_osc_en_o &&
		rtc_crystal_osc_en_o && nano_ring_osc_en_o && !main_core_pwr_o))
		else $error("backup retention wrong");
	AST_PDM_OFF: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(s.seq == SEQ_RUN && s.mode == MODE_POWER_DOWN) |->
		(bank_retain_o == 4'h0 && !rtc_crystal_osc_en_o && volt_mon_en_o))
		else $error("power down state wrong");
	AST_OSC_FIRST: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		$rose(main_core_run_o) |->
		$past(primary_osc_en_o && secondary_osc_en_o && baud_osc_en_o))
		else $error("core released before oscillators");
endmodule

// ==== verif/power_mode_controller_tb_top.sv ====
// Purpose: Self-checking bench for the power mode controller
// Assumes: Classic Wishbone master, one 10 MHz clock, no partner model
// Notes:   Wake latency counted from the edge that samples the wake source
`timescale 1ns/10ps
module power_mode_controller_tb_top;
	import power_mode_pkg::*;

	localparam int LIMIT = 5000;
	// Edges from the wake sampling edge to core release
	localparam int WARM_N = int'(OSC_START_CYC);
	localparam int COLD_N = int'(OSC_START_CYC + SYS_INIT_CYC);

	logic                sys_clk_i;
	logic                reset_i;
	logic                wb_cyc_i;
	logic                wb_stb_i;
	logic                wb_we_i;
	logic [7:0]          wb_adr_i;
	logic [3:0]          wb_sel_i;
	logic [31:0]         wb_dat_i;
	logic [31:0]         wb_dat_o;
	logic                wb_ack_o;
	logic                external_reset_pin_n_i;
	logic [WAKE_W-1:0]   wake_i;
	logic [15:0]         periph_irq_i;
	logic [15:0]         periph_req_i;
	mode_t               mode_o;
	logic                main_core_pwr_o;
	logic                main_core_run_o;
	logic                cop_core_pwr_o;
	logic                cop_core_run_o;
	logic [3:0]          bank_pwr_o;
	logic [3:0]          bank_retain_o;
	logic [3:0]          cop_bank_access_o;
	logic                bank3_icache_o;
	logic                accel_quad_pwr_o;
	logic                accel_mem_retain_o;
	logic                periph_pwr_o;
	logic                periph_run_o;
	logic [15:0]         periph_clk_en_o;
	logic                dma_en_o;
	logic                dma_flash_en_o;
	logic                gpio_hold_o;
	logic                primary_osc_en_o;
	logic                secondary_osc_en_o;
	logic                baud_osc_en_o;
	logic                rtc_crystal_osc_en_o;
	logic                nano_ring_osc_en_o;
	logic                volt_mon_en_o;
	int                  errors;
	int                  n_checks;
	int                  cycles;
	logic [31:0]         rd;

	power_mode_controller u_power_mode_controller (.*);

	initial begin
		sys_clk_i = 1'b0;
		forever #50 sys_clk_i = ~sys_clk_i;
	end

	// A hang lands in the same closing report as a normal end
	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			errors++;
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wb_cycle(input logic we, input logic [7:0] adr,
		input logic [3:0] sel, input logic [31:0] dat);
		int n;
		@(posedge sys_clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= dat;
		n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		if (wb_ack_o !== 1'b1) chk({31'h0, wb_ack_o}, 32'h1);
	endtask

	task automatic settle();
		@(posedge sys_clk_i);
		#1;
	endtask

	function automatic logic [31:0] snap();
		return {20'h0, main_core_pwr_o, main_core_run_o, cop_core_pwr_o,
			cop_core_run_o, periph_pwr_o, gpio_hold_o, accel_quad_pwr_o,
			primary_osc_en_o, secondary_osc_en_o, baud_osc_en_o,
			rtc_crystal_osc_en_o, nano_ring_osc_en_o};
	endfunction

	task automatic pulse(input int kind, input int b);
		@(posedge sys_clk_i);
		if (kind == 0) wake_i[b] <= 1'b1;
		else if (kind == 1) periph_irq_i[b] <= 1'b1;
		else external_reset_pin_n_i <= 1'b0;
		@(posedge sys_clk_i);
		wake_i <= '0;
		periph_irq_i <= '0;
		external_reset_pin_n_i <= 1'b1;
	endtask

	task automatic enter(input logic [2:0] code, input logic [31:0] exp,
		input logic [31:0] mask);
		wb_cycle(1'b1, ADDR_CTRL, 4'h1, {29'h0, code});
		settle();
		chk({29'h0, mode_o}, {29'h0, code});
		chk(snap() & mask, exp);
	endtask

	task automatic no_wake(input int kind, input int b, input logic [2:0] m);
		pulse(kind, b);
		repeat (15) @(posedge sys_clk_i);
		#1;
		chk({29'h0, mode_o}, {29'h0, m});
		chk({31'h0, main_core_run_o}, 32'h0);
	endtask

	task automatic wake_timed(input int kind, input int b,
		input logic [2:0] old, input int exp_n);
		int n;
		pulse(kind, b);
		n = 0;
		do begin
			settle();
			n++;
			if (n == 2) begin
				chk(snap() & 32'hF1F, 32'hA1F);
				chk({29'h0, mode_o}, {29'h0, old});
			end
		end while (main_core_run_o !== 1'b1 && n < 100);
		chk(32'(n), 32'(exp_n));
		chk({29'h0, mode_o}, 32'h0);
	endtask

	task automatic t_reset();
		chk({29'h0, mode_o}, 32'h0);
		chk(snap() & 32'hF00, 32'hF00);
		chk({28'h0, cop_bank_access_o}, 32'hC);
		chk({28'h0, bank_pwr_o}, 32'hF);
		chk({31'h0, periph_run_o}, 32'h1);
		wb_cycle(1'b0, ADDR_CFG, 4'hF, 32'h0);
		chk(rd, {24'h0, CFG_RESET});
		wb_cycle(1'b0, ADDR_IRQ_EN, 4'hF, 32'h0);
		chk(rd, {16'h0, IRQ_EN_RESET});
		wb_cycle(1'b0, ADDR_STATUS, 4'hF, 32'h0);
		chk(rd, 32'h10);
		wb_cycle(1'b0, 8'h20, 4'hF, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, bank3_icache_o}, 32'h0);
		wb_cycle(1'b1, ADDR_CFG, 4'h1, 32'h51);
		settle();
		chk({31'h0, bank3_icache_o}, 32'h1);
		$display("test reset done");
	endtask

	task automatic t_clock();
		@(posedge sys_clk_i);
		periph_req_i <= 16'h00A5;
		repeat (3) settle();
		chk({16'h0, periph_clk_en_o}, 32'h00A5);
		@(posedge sys_clk_i);
		periph_req_i <= 16'h0000;
		repeat (3) settle();
		chk({16'h0, periph_clk_en_o}, 32'h0);
		$display("test clocking done");
	endtask

	task automatic t_sleep();
		wb_cycle(1'b1, ADDR_CFG, 4'h1, 32'h5F);
		wb_cycle(1'b1, ADDR_IRQ_EN, 4'h3, 32'h0004);
		enter(3'h1, 32'h080, 32'h580);
		chk({31'h0, dma_en_o}, 32'h1);
		chk({31'h0, accel_quad_pwr_o}, 32'h1);
		no_wake(1, 1, 3'h1);
		wake_timed(1, 2, 3'h1, WARM_N);
		enter(3'h1, 32'h080, 32'h580);
		wake_timed(2, 0, 3'h1, WARM_N);
		$display("test sleep done");
	endtask

	task automatic t_low_modes();
		enter(3'h2, 32'h90F, 32'hD0F);
		chk({30'h0, bank_retain_o[1:0]}, 32'h3);
		chk({28'h0, cop_bank_access_o}, 32'hC);
		chk({31'h0, bank3_icache_o}, 32'h1);
		chk({31'h0, dma_flash_en_o}, 32'h1);
		chk({31'h0, primary_osc_en_o}, 32'h0);
		chk({28'h0, bank_pwr_o}, 32'hC);
		no_wake(0, W_LP_UART, 3'h2);
		wake_timed(0, W_COPROC, 3'h2, WARM_N);
		wb_cycle(1'b0, ADDR_WAKE_CAUSE, 4'hF, 32'h0);
		chk(rd, 32'h400);
		enter(3'h3, 32'hA47, 32'hF7F);
		chk({28'h0, bank_retain_o}, 32'hF);
		chk({31'h0, accel_mem_retain_o}, 32'h1);
		chk({31'h0, periph_run_o}, 32'h0);
		no_wake(0, W_SPI, 3'h3);
		wake_timed(0, W_LP_TMR_B, 3'h3, WARM_N);
		enter(3'h4, 32'h043, 32'h57F);
		no_wake(0, W_UART, 3'h4);
		wake_timed(0, W_CMP_ZERO, 3'h4, WARM_N);
		enter(3'h5, 32'h003, 32'hF9F);
		chk({28'h0, bank_retain_o}, 32'h5);
		no_wake(0, W_CMP_ANY, 3'h5);
		wake_timed(0, W_RTC, 3'h5, COLD_N);
		enter(3'h6, 32'h000, 32'hF9F);
		chk({31'h0, volt_mon_en_o}, 32'h1);
		chk({28'h0, bank_retain_o}, 32'h0);
		no_wake(0, W_GPIO, 3'h6);
		wake_timed(0, W_P3_ONE, 3'h6, COLD_N);
		enter(3'h6, 32'h000, 32'hF9F);
		wake_timed(2, 0, 3'h6, COLD_N);
		$display("test low modes done");
	endtask

	task automatic t_refuse();
		wb_cycle(1'b1, ADDR_CTRL, 4'h1, 32'h7);
		settle();
		chk({29'h0, mode_o}, 32'h0);
		wb_cycle(1'b1, ADDR_CTRL, 4'h0, 32'h2);
		settle();
		chk({29'h0, mode_o}, 32'h0);
		chk({31'h0, main_core_run_o}, 32'h1);
		$display("test refused entry done");
	endtask

	initial begin
		errors = 0;
		n_checks = 0;
		cycles = 0;
		reset_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		external_reset_pin_n_i = 1'b1;
		wake_i = '0;
		periph_irq_i = 16'h0000;
		periph_req_i = 16'h0000;
		repeat (5) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		repeat (3) settle();
		t_reset();
		t_clock();
		t_refuse();
		t_sleep();
		t_low_modes();
		summarize();
	end
endmodule
